//--- hdl/fxmon_pkg.sv
// Shared constants, types and register map of the fixing unit fault monitor
package fxmon_pkg;

  // Timebase
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES =
    (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Timing counts in 1 ms ticks
  localparam int OVF_FAIL_TIME_S = 2;
  localparam logic [10:0] OVF_FAIL_MS = 11'(OVF_FAIL_TIME_S * 1000);
  localparam int TOGGLE_TIMEOUT_TIME_MS = 100;
  localparam logic [10:0] TOGGLE_TIMEOUT_MS = 11'(TOGGLE_TIMEOUT_TIME_MS);
  localparam int SOL_PULSE_TIME_MS = 50;
  localparam logic [10:0] SOL_PULSE_MS = 11'(SOL_PULSE_TIME_MS);

  // Print counts after warnings
  localparam logic [5:0] OIL_LOW_SHEETS = 6'd50;
  localparam logic [9:0] BELT_END_PRINTS = 10'd500;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_REPORT = 8'h04;
  localparam logic [7:0] ADDR_EVENT = 8'h08;
  localparam logic [7:0] ADDR_EVT_EN = 8'h0c;
  localparam logic [7:0] ADDR_EVT_CLR = 8'h10;
  localparam logic [7:0] ADDR_COUNT = 8'h14;
  localparam logic [7:0] ADDR_STATE = 8'h18;

  // Control register fields
  localparam int CTRL_CHECK_BIT = 0;
  localparam int CTRL_OHP_BIT = 1;
  localparam int CTRL_UPPER_BIT = 2;
  localparam int CTRL_LOWER_BIT = 3;
  localparam int CTRL_IVL_LSB = 8;
  localparam int CTRL_IVL_W = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_1400;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_ff0e;

  // Count register fields
  localparam int COUNT_OIL_LSB = 0;
  localparam int COUNT_BELT_LSB = 16;

  // State register fields
  localparam int STATE_HC_LSB = 0;
  localparam int STATE_SB_LSB = 8;
  localparam int STATE_PEND_LSB = 12;

  // Reported conditions, also the event layout
  localparam int REPORT_W = 9;
  typedef struct packed {
    logic print_stop;
    logic belt_none;
    logic belt_low;
    logic ovf_fail;
    logic ovf;
    logic oil_out;
    logic oil_low;
    logic fix_fail;
    logic psu_fail;
  } fxmon_report_s;

  // Sense inputs after filtering
  localparam int SENSE_W = 5;
  typedef struct packed {
    logic belt_end;
    logic overflow;
    logic oil_low;
    logic fault_status;
    logic trip;
  } fxmon_sense_s;

  typedef enum logic [4:0] {
    HC_IDLE = 5'b00001,
    HC_UPPER = 5'b00010,
    HC_LOWER = 5'b00100,
    HC_PASS = 5'b01000,
    HC_FAIL = 5'b10000
  } fxmon_hc_e;

  typedef enum logic [2:0] {
    SB_IDLE = 3'b001,
    SB_ON = 3'b010,
    SB_OFF = 3'b100
  } fxmon_sb_e;

endpackage

//--- hdl/fxmon_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module fxmon_sync import fxmon_pkg::*; #(
  parameter int W = SENSE_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins and filtered levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  // Output follows only when stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;

endmodule

//--- hdl/fxmon_tick.sv
// Free-running millisecond tick generator
`timescale 1ns/100ps
module fxmon_tick import fxmon_pkg::*; #(
  parameter int CYCLES = TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // One-cycle pulse per period
  output logic tick
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  always_comb begin
    if (cnt_q == CW'(CYCLES - 1)) begin
      cnt_d = '0;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 1'b1;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

//--- hdl/fxmon_top.sv
// Fixing unit fault monitor with APB register access
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
// Operation
// - Trip sense high: fixing failure, reported as power supply failure.
// - Trip stays latched until power is cycled after a long off time.
// - Fault status high with heaters off means wrong rated voltage unit.
// - At temperature control start, check upper then lower heater alone.
// - Fault status toggling while a heater is driven proves it intact.
// - Status low while driven: broken wire, fixing failure, heaters off.
// - Oil-low sense high raises an oil-low warning.
// - About fifty sheets after oil-low, declare oil out and stop.
// - Overflow sense high stops the printer and reports oil overflow.
// - Overflow high for two seconds or more reports overflow failure.
// - Advance the cleaning belt after each set number of prints.
// - One solenoid pulse per step; transparency mode gives two steps.
// - Belt-end sense high warns that the belt is nearly used up.
// - About five hundred prints after belt-end, report no belt and stop.
// - Upper and lower heaters each have their own active-low drive.
module fxmon_top import fxmon_pkg::*; #(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Sense pins
  input wire logic OVERTEMP_TRIP_SENSE,
  input wire logic FIXING_FAULT_STATUS,
  input wire logic OIL_LOW_SENSE,
  input wire logic OIL_OVERFLOW_SENSE,
  input wire logic BELT_END_SENSE,
  // Engine logic, same clock
  input wire logic PRINT_DONE,
  // Actuators
  output logic UPPER_HEATER_DRIVE_N,
  output logic LOWER_HEATER_DRIVE_N,
  output logic BELT_STEP_SOLENOID,
  // Video controller notices and interrupt
  output fxmon_report_s REPORT,
  output logic IRQ
);

  logic tick;
  logic [SENSE_W-1:0] sense_vec;
  fxmon_sense_s sense;

  // Timebase
  fxmon_tick #(
    .CYCLES(TICK_LEN)
  ) u_tick (
    .clk(CLK),
    .rst(SYS_RST),
    .tick(tick)
  );

  fxmon_sync #(
    .W(SENSE_W)
  ) u_sync (
    .clk(CLK),
    .rst(SYS_RST),
    .din({BELT_END_SENSE, OIL_OVERFLOW_SENSE, OIL_LOW_SENSE,
          FIXING_FAULT_STATUS, OVERTEMP_TRIP_SENSE}),
    .dout(sense_vec)
  );

  assign sense = fxmon_sense_s'(sense_vec);

  // APB and register state
  logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
  logic [31:0] prdata_q, prdata_d, ctrl_q, ctrl_d;
  logic [REPORT_W-1:0] event_q, event_d, en_q, en_d, clr;
  logic access, done, wr, mapped, check_start;
  // Fault state
  fxmon_hc_e hc_q, hc_d;
  fxmon_sb_e sb_q, sb_d;
  logic [10:0] hc_ms_q, hc_ms_d, ovf_ms_q, ovf_ms_d, sb_ms_q, sb_ms_d;
  logic fs_q, fs_d, fs_edge, trip_q, trip_d, mism_q, mism_d;
  logic ovf_fail_q, ovf_fail_d, oil_low_q, oil_low_d;
  logic oil_out_q, oil_out_d, belt_low_q, belt_low_d;
  logic belt_none_q, belt_none_d, heat_block;
  logic [5:0] oil_cnt_q, oil_cnt_d;
  logic [9:0] belt_cnt_q, belt_cnt_d;
  logic [7:0] ivl_cnt_q, ivl_cnt_d, ivl;
  logic [2:0] pend_q, pend_d;
  logic upper_n_q, upper_n_d, lower_n_q, lower_n_d, sol_q, sol_d;
  fxmon_report_s report_q, report_d;

  assign access = PSEL & PENABLE;
  assign done = access & pready_q;
  assign wr = done & PWRITE;
  assign ivl = ctrl_q[CTRL_IVL_LSB +: CTRL_IVL_W];
  assign check_start = wr & (PADDR == ADDR_CTRL) & PWDATA[CTRL_CHECK_BIT];
  assign clr = (wr & (PADDR == ADDR_EVT_CLR)) ?
               PWDATA[REPORT_W-1:0] : '0;
  // Map is contiguous aligned words from zero up to the state word
  assign mapped = (PADDR <= ADDR_STATE) & (PADDR[1:0] == 2'b00);

  // Bus slave: one wait state, read data latched on the same edge as pready
  always_comb begin
    pready_d = access & ~pready_q;
    pslverr_d = access & ~pready_q & ~mapped;
    prdata_d = prdata_q;
    if (access & ~pready_q) begin
      prdata_d = '0;
      if (!PWRITE) begin
        unique case (PADDR)
          ADDR_CTRL: prdata_d = ctrl_q;
          ADDR_REPORT: prdata_d[REPORT_W-1:0] = report_q;
          ADDR_EVENT: prdata_d[REPORT_W-1:0] = event_q;
          ADDR_EVT_EN: prdata_d[REPORT_W-1:0] = en_q;
          ADDR_COUNT: begin
            prdata_d[COUNT_OIL_LSB +: 6] = oil_cnt_q;
            prdata_d[COUNT_BELT_LSB +: 10] = belt_cnt_q;
          end
          ADDR_STATE: begin
            prdata_d[STATE_HC_LSB +: 5] = hc_q;
            prdata_d[STATE_SB_LSB +: 3] = sb_q;
            prdata_d[STATE_PEND_LSB +: 3] = pend_q;
          end
          default: prdata_d = '0;
        endcase
      end
    end
    ctrl_d = ctrl_q;
    en_d = en_q;
    if (wr & (PADDR == ADDR_CTRL)) begin
      ctrl_d = PWDATA & CTRL_WMASK;
    end
    if (wr & (PADDR == ADDR_EVT_EN)) begin
      en_d = PWDATA[REPORT_W-1:0];
    end
    // Set wins over a clear in the same cycle
    event_d = (event_q & ~clr) | (report_d & ~report_q);
    irq_d = |(event_d & en_d);
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      ctrl_q <= CTRL_RESET;
      event_q <= '0;
      en_q <= '0;
      irq_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      ctrl_q <= ctrl_d;
      event_q <= event_d;
      en_q <= en_d;
      irq_q <= irq_d;
    end
  end

  // Heater breakage check and heater drive
  always_comb begin
    fs_d = sense.fault_status;
    hc_d = hc_q;
    hc_ms_d = tick ? hc_ms_q + 11'd1 : hc_ms_q;
    unique case (hc_q)
      HC_IDLE: begin
        hc_ms_d = '0;
        if (check_start & ~heat_block) begin
          hc_d = HC_UPPER;
        end
      end
      HC_UPPER: begin
        if (fs_edge) begin
          hc_d = HC_LOWER;
          hc_ms_d = '0;
        end else if (hc_ms_q >= TOGGLE_TIMEOUT_MS) begin
          hc_d = sense.fault_status ? HC_IDLE : HC_FAIL;
        end
      end
      HC_LOWER: begin
        if (fs_edge) begin
          hc_d = HC_PASS;
        end else if (hc_ms_q >= TOGGLE_TIMEOUT_MS) begin
          hc_d = sense.fault_status ? HC_IDLE : HC_FAIL;
        end
      end
      HC_PASS, HC_FAIL: hc_ms_d = '0;
    endcase
    if (heat_block & (hc_q != HC_FAIL)) begin
      hc_d = HC_IDLE;
    end
    // Only one heater at a time during the check
    upper_n_d = ~(~heat_block & ((hc_q == HC_UPPER) |
                 ((hc_q == HC_PASS) & ctrl_q[CTRL_UPPER_BIT])));
    lower_n_d = ~(~heat_block & ((hc_q == HC_LOWER) |
                 ((hc_q == HC_PASS) & ctrl_q[CTRL_LOWER_BIT])));
  end

  assign fs_edge = fs_q ^ sense.fault_status;
  assign heat_block = trip_q | mism_q | (hc_q == HC_FAIL);
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      fs_q <= 1'b0;
      hc_q <= HC_IDLE;
      hc_ms_q <= '0;
      upper_n_q <= 1'b1;
      lower_n_q <= 1'b1;
    end else begin
      fs_q <= fs_d;
      hc_q <= hc_d;
      hc_ms_q <= hc_ms_d;
      upper_n_q <= upper_n_d;
      lower_n_q <= lower_n_d;
    end
  end

  // Latched faults, oil and belt counting
  always_comb begin
    // Trip clears only at power-on reset
    trip_d = trip_q | sense.trip;
    // Status is meaningful only while no heater is under test
    mism_d = mism_q | (sense.fault_status & (hc_q == HC_IDLE)
                       & upper_n_q & lower_n_q);
    ovf_ms_d = sense.overflow ?
               ovf_ms_q + 11'(tick & (ovf_ms_q < OVF_FAIL_MS)) : '0;
    ovf_fail_d = ovf_fail_q | (ovf_ms_q >= OVF_FAIL_MS);
    oil_low_d = oil_low_q | sense.oil_low;
    oil_out_d = oil_out_q | (oil_cnt_q == OIL_LOW_SHEETS);
    belt_low_d = belt_low_q | sense.belt_end;
    belt_none_d = belt_none_q | (belt_cnt_q == BELT_END_PRINTS);
    oil_cnt_d = oil_cnt_q;
    if (!oil_low_q) begin
      oil_cnt_d = '0;
    end else if (PRINT_DONE & (oil_cnt_q != OIL_LOW_SHEETS)) begin
      oil_cnt_d = oil_cnt_q + 6'd1;
    end
    belt_cnt_d = belt_cnt_q;
    if (!belt_low_q) begin
      belt_cnt_d = '0;
    end else if (PRINT_DONE & (belt_cnt_q != BELT_END_PRINTS)) begin
      belt_cnt_d = belt_cnt_q + 10'd1;
    end
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      trip_q <= 1'b0;
      mism_q <= 1'b0;
      ovf_ms_q <= '0;
      ovf_fail_q <= 1'b0;
      oil_low_q <= 1'b0;
      oil_out_q <= 1'b0;
      belt_low_q <= 1'b0;
      belt_none_q <= 1'b0;
      oil_cnt_q <= '0;
      belt_cnt_q <= '0;
    end else begin
      trip_q <= trip_d;
      mism_q <= mism_d;
      ovf_ms_q <= ovf_ms_d;
      ovf_fail_q <= ovf_fail_d;
      oil_low_q <= oil_low_d;
      oil_out_q <= oil_out_d;
      belt_low_q <= belt_low_d;
      belt_none_q <= belt_none_d;
      oil_cnt_q <= oil_cnt_d;
      belt_cnt_q <= belt_cnt_d;
    end
  end

  // Cleaning belt stepping; interval zero disables stepping
  always_comb begin
    ivl_cnt_d = ivl_cnt_q;
    pend_d = pend_q;
    if (PRINT_DONE & (ivl != 8'h00)) begin
      if (ivl_cnt_q + 8'd1 >= ivl) begin
        ivl_cnt_d = '0;
        // Saturate rather than wrap if prints outrun the solenoid
        if (ctrl_q[CTRL_OHP_BIT]) begin
          pend_d = (pend_q > 3'd5) ? 3'd7 : pend_q + 3'd2;
        end else begin
          pend_d = (pend_q == 3'd7) ? 3'd7 : pend_q + 3'd1;
        end
      end else begin
        ivl_cnt_d = ivl_cnt_q + 8'd1;
      end
    end
    sb_d = sb_q;
    sb_ms_d = tick ? sb_ms_q + 11'd1 : sb_ms_q;
    sol_d = 1'b0;
    unique case (sb_q)
      SB_IDLE: begin
        sb_ms_d = '0;
        if (pend_d != 3'd0) begin
          sb_d = SB_ON;
          pend_d = pend_d - 3'd1;
        end
      end
      SB_ON: begin
        sol_d = 1'b1;
        if (sb_ms_q >= SOL_PULSE_MS) begin
          sb_d = SB_OFF;
          sb_ms_d = '0;
          sol_d = 1'b0;
        end
      end
      SB_OFF: begin
        if (sb_ms_q >= SOL_PULSE_MS) begin
          sb_d = SB_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ivl_cnt_q <= '0;
      pend_q <= '0;
      sb_q <= SB_IDLE;
      sb_ms_q <= '0;
      sol_q <= 1'b0;
    end else begin
      ivl_cnt_q <= ivl_cnt_d;
      pend_q <= pend_d;
      sb_q <= sb_d;
      sb_ms_q <= sb_ms_d;
      sol_q <= sol_d;
    end
  end

  // Notices to the video controller
  always_comb begin
    report_d.psu_fail = trip_q | mism_q;
    report_d.fix_fail = trip_q | (hc_q == HC_FAIL);
    report_d.oil_low = oil_low_q;
    report_d.oil_out = oil_out_q;
    report_d.ovf = sense.overflow;
    report_d.ovf_fail = ovf_fail_q;
    report_d.belt_low = belt_low_q;
    report_d.belt_none = belt_none_q;
    report_d.print_stop = oil_out_q | sense.overflow | ovf_fail_q |
                          belt_none_q | heat_block;
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      report_q <= '0;
    end else begin
      report_q <= report_d;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign UPPER_HEATER_DRIVE_N = upper_n_q;
  assign LOWER_HEATER_DRIVE_N = lower_n_q;
  assign BELT_STEP_SOLENOID = sol_q;
  assign REPORT = report_q;
  assign IRQ = irq_q;

endmodule

//--- sim/fxmon_monitor.sv
// Port assertions for the fixing unit fault monitor
`timescale 1ns/100ps
module fxmon_monitor import fxmon_pkg::*; #(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // APB handshake
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Sense pins and prints
  input wire logic OVERTEMP_TRIP_SENSE,
  input wire logic OIL_OVERFLOW_SENSE,
  input wire logic PRINT_DONE,
  // Actuators and notices
  input wire logic UPPER_HEATER_DRIVE_N,
  input wire logic LOWER_HEATER_DRIVE_N,
  input wire logic BELT_STEP_SOLENOID,
  input wire fxmon_report_s REPORT
);
  // Prints after each warning, cycles with overflow pin high
  logic [9:0] oil_q, oil_d, belt_q, belt_d;
  logic [31:0] hi_q, hi_d;
  logic fault;
  always_comb begin
    oil_d = oil_q + 10'(PRINT_DONE && REPORT.oil_low);
    belt_d = belt_q + 10'(PRINT_DONE && REPORT.belt_low);
    hi_d = OIL_OVERFLOW_SENSE ? hi_q + 32'h1 : 32'h0;
    fault = REPORT.psu_fail || REPORT.fix_fail || REPORT.oil_out ||
      REPORT.belt_none;
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      oil_q <= 10'h0;
      belt_q <= 10'h0;
      hi_q <= 32'h0;
    end else begin
      oil_q <= oil_d;
      belt_q <= belt_d;
      hi_q <= hi_d;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_apb_wait: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
    else $error("ready not two cycles after setup");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_err_in_ready: assert property (PSLVERR |-> PREADY && PENABLE)
    else $error("error outside a ready cycle");
  a_trip_report: assert property (
    $rose(OVERTEMP_TRIP_SENSE) |-> ##[1:8]
    (REPORT.psu_fail && REPORT.fix_fail))
    else $error("trip not reported");
  a_fault_hold: assert property (
    !$fell(REPORT.psu_fail) && !$fell(REPORT.fix_fail) &&
    !$fell(REPORT.oil_out) && !$fell(REPORT.belt_none) &&
    !$fell(REPORT.ovf_fail))
    else $error("latched failure dropped");
  a_fault_stop: assert property (
    fault |-> ##[0:1] REPORT.print_stop)
    else $error("failure without print stop");
  a_broken_off: assert property (
    REPORT.fix_fail && !REPORT.psu_fail |->
    UPPER_HEATER_DRIVE_N && LOWER_HEATER_DRIVE_N)
    else $error("heater driven after broken wire");
  a_oil_count: assert property (
    $rose(REPORT.oil_out) |-> oil_q == 10'h32)
    else $error("oil out at wrong sheet count");
  a_belt_count: assert property (
    $rose(REPORT.belt_none) |-> belt_q == 10'h1f4)
    else $error("no belt at wrong print count");
  a_ovf_show: assert property (
    $rose(OIL_OVERFLOW_SENSE) |-> ##[1:8] REPORT.ovf)
    else $error("overflow not shown");
  a_ovf_time: assert property (
    $rose(REPORT.ovf_fail) |-> hi_q >= 32'(1999 * TICK_LEN) &&
    hi_q <= 32'(2001 * TICK_LEN + 8))
    else $error("overflow failure at wrong time");
  a_sol_pulse: assert property (
    $rose(BELT_STEP_SOLENOID) |-> BELT_STEP_SOLENOID [*8])
    else $error("solenoid pulse too short");
endmodule
bind fxmon_top fxmon_monitor #(.TICK_LEN(TICK_LEN)) mon_u (
  .CLK, .SYS_RST, .PSEL, .PENABLE, .PREADY, .PSLVERR,
  .OVERTEMP_TRIP_SENSE, .OIL_OVERFLOW_SENSE, .PRINT_DONE,
  .UPPER_HEATER_DRIVE_N, .LOWER_HEATER_DRIVE_N, .BELT_STEP_SOLENOID,
  .REPORT);

//--- sim/fxmon_video.sv
// Video controller model that keeps every notice it has seen
`timescale 1ns/100ps
module fxmon_video import fxmon_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Notices in, notices seen out
  input wire fxmon_report_s notice,
  output fxmon_report_s seen
);
  fxmon_report_s seen_q, seen_d;
  always_comb begin
    seen_d = seen_q | notice;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_q <= '0;
    end else begin
      seen_q <= seen_d;
    end
  end
  assign seen = seen_q;
endmodule

//--- sim/tb.sv
// Self-checking bench for the fixing unit fault monitor
`timescale 1ns/100ps
module tb import fxmon_pkg::*;;
  localparam int TL = 10;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic trip, flt, oil, ovf, belt, pd, up_n, lo_n, sol, irq;
  fxmon_report_s report, seen;
  int fail_count, tests_run;
  fxmon_top #(.TICK_LEN(TL)) dut_u (
    .CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .OVERTEMP_TRIP_SENSE(trip),
    .FIXING_FAULT_STATUS(flt), .OIL_LOW_SENSE(oil),
    .OIL_OVERFLOW_SENSE(ovf), .BELT_END_SENSE(belt), .PRINT_DONE(pd),
    .UPPER_HEATER_DRIVE_N(up_n), .LOWER_HEATER_DRIVE_N(lo_n),
    .BELT_STEP_SOLENOID(sol), .REPORT(report), .IRQ(irq));
  fxmon_video vc_u (.clk(clk), .rst(rst), .notice(report), .seen(seen));
  task automatic report_and_stop();
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rpt(input logic [8:0] e);
    chk({23'h0, report}, {23'h0, e});
  endtask
  task automatic heat(input logic [1:0] e);
    chk({30'h0, up_n, lo_n}, {30'h0, e});
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    chk({31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic reset_dut();
    rst <= 1'h1;
    {trip, flt, oil, ovf, belt, pd} <= 6'h0;
    cyc(6);
    rst <= 1'h0;
    cyc(2);
  endtask
  task automatic prints(input int k);
    repeat (k) begin
      pd <= 1'h1;
      cyc(1);
      pd <= 1'h0;
      cyc(3);
    end
  endtask
  task automatic sol_count(input int k, input int e);
    int c;
    logic p;
    c = 0;
    // The step starts one edge after the print, before this window opens
    p = 1'b0;
    repeat (k) begin
      @(posedge clk);
      if (sol && !p) c++;
      p = sol;
    end
    chk(32'(c), 32'(e));
  endtask
  task automatic t_regs();
    reset_dut();
    apb(1'h0, ADDR_CTRL, 32'h0);
    chk(rd, CTRL_RESET);
    apb(1'h1, ADDR_CTRL, 32'hffff_fffe);
    apb(1'h0, ADDR_CTRL, 32'h0);
    chk(rd, CTRL_WMASK);
    apb(1'h1, ADDR_REPORT, 32'hffff_ffff);
    chk({31'h0, err}, 32'h0);
    apb(1'h0, ADDR_REPORT, 32'h0);
    chk(rd, 32'h0);
    // Unmapped word just past the map
    apb(1'h0, 8'h1c, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask
  task automatic t_trip();
    reset_dut();
    apb(1'h1, ADDR_EVT_EN, 32'h0);
    trip <= 1'h1;
    cyc(8);
    rpt(9'h103);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, ADDR_EVT_EN, 32'h1);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    apb(1'h0, ADDR_EVENT, 32'h0);
    chk(rd, 32'h103);
    apb(1'h1, ADDR_EVT_CLR, 32'h1ff);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    trip <= 1'h0;
    cyc(8);
    rpt(9'h103);
  endtask
  task automatic start_check();
    reset_dut();
    apb(1'h1, ADDR_CTRL, 32'h1401);
    cyc(3);
    heat(2'h1);
  endtask
  task automatic t_heat_ok();
    start_check();
    flt <= 1'h1;
    cyc(10);
    heat(2'h2);
    flt <= 1'h0;
    cyc(10);
    heat(2'h3);
    apb(1'h1, ADDR_CTRL, 32'h1404);
    cyc(3);
    heat(2'h1);
    apb(1'h1, ADDR_CTRL, 32'h1408);
    cyc(3);
    heat(2'h2);
    rpt(9'h0);
  endtask
  task automatic t_heat_broken();
    // Status never toggles: timeout is 100 ticks
    start_check();
    cyc(1100);
    rpt(9'h102);
    heat(2'h3);
  endtask
  task automatic t_mismatch();
    reset_dut();
    flt <= 1'h1;
    cyc(8);
    rpt(9'h101);
    apb(1'h1, ADDR_CTRL, 32'h1401);
    cyc(3);
    heat(2'h3);
  endtask
  task automatic t_oil();
    reset_dut();
    // Prints before the warning must not count
    prints(3);
    oil <= 1'h1;
    cyc(8);
    rpt(9'h004);
    prints(49);
    rpt(9'h004);
    apb(1'h0, ADDR_COUNT, 32'h0);
    chk(rd & 32'h3f, 32'h31);
    prints(1);
    cyc(4);
    rpt(9'h10c);
    chk({23'h0, seen}, 32'h10c);
  endtask
  task automatic t_ovf();
    reset_dut();
    ovf <= 1'h1;
    cyc(8);
    rpt(9'h110);
    cyc(19890);
    rpt(9'h110);
    cyc(150);
    rpt(9'h130);
    ovf <= 1'h0;
    cyc(8);
    chk({23'h0, report} & 32'h30, 32'h20);
  endtask
  task automatic t_step();
    reset_dut();
    apb(1'h1, ADDR_CTRL, 32'h0200);
    prints(1);
    cyc(20);
    chk({31'h0, sol}, 32'h0);
    prints(1);
    sol_count(1500, 1);
    apb(1'h1, ADDR_CTRL, 32'h0202);
    prints(2);
    sol_count(2600, 2);
  endtask
  task automatic t_belt_end();
    reset_dut();
    apb(1'h1, ADDR_CTRL, 32'h0);
    belt <= 1'h1;
    cyc(8);
    rpt(9'h040);
    prints(499);
    rpt(9'h040);
    prints(1);
    cyc(4);
    rpt(9'h1c0);
  endtask
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // Full run is near 28000 cycles; allow about twice that
  initial begin
    #240000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    {rst, psel, penable, pwrite} = 4'h8;
    paddr = 8'h0;
    pwdata = 32'h0;
    {trip, flt, oil, ovf, belt, pd} = 6'h0;
    fail_count = 0;
    tests_run = 0;
    t_regs();
    t_trip();
    t_heat_ok();
    t_heat_broken();
    t_mismatch();
    t_oil();
    t_ovf();
    t_step();
    t_belt_end();
    report_and_stop();
  end
endmodule
